// [hdl/aps_dev.sv]
// Purpose: digital control and port logic of a 4-input sampling converter
// Assumes: port pins synchronous to CLK; front end supplies coded samples
// Notes:   control register layouts are local choices
`timescale 1ns/1ps

// What this block does
// R1: access needs high select driven high
// R2: access also needs low select driven low
// R3: read qualifier combines both selects and read
// R4: marker flags the first-channel output word
// R5: marker low on first channel, idle single-channel
// R6: words cycle channel one through N
// R7: ten-bit shared bus, host writes, device reads
// R8: address lines choose control register 0 or 1
// R9: register 0 picks internal or external reference
// R10: write line is combined r/w or strobe
// R11: read strobe honoured only in strobe mode
// R12: host writes first before any read
// R13: host supplies free-running 50% conversion clock
// R14: each falling clock edge starts a conversion
// R15: result appears five conversion clocks later
// R16: first marker waits seven plus channel count
// R17: four inputs sampled together, selection programmable
// R18: bus released whenever read qualifier inactive
module aps_dev
  import aps_pkg::*;
(
  input  wire logic             CLK,          // system clock
  input  wire logic             RST,          // sync reset, high
  input  wire aps_pkg::aps_set_t SAMPLE,      // coded values of inputs a..d
  output logic                  REF_EXTERNAL, // 1 = use external reference
  output logic [2:0]            CHAN_COUNT,   // channels in the scan
  aps_if.dev                    port          // host pins
);
  aps_word_t   cr0;
  aps_word_t   cr1;
  logic        wr_prev;
  aps_word_t   wr_data;
  logic [1:0]  wr_addr;
  logic        cc_prev;
  logic [1:0]  idx;
  aps_set_t    held;
  aps_word_t   pipe_data [APS_LATENCY];
  logic        pipe_first [APS_LATENCY];
  aps_word_t   out_word;
  logic        out_first;
  logic [3:0]  hold_cnt;

  // ----------------------------------------
  // channel list decoding
  // ----------------------------------------
  // a differential pair counts once and is carried by its even input
  function automatic logic [3:0] active_inputs(input aps_word_t c);
    logic [3:0] en;
    en = c[APS_CR0_CHEN +: 4];
    if (c[APS_CR0_DIFF_AB]) en[1] = 1'b0;
    if (c[APS_CR0_DIFF_CD]) en[3] = 1'b0;
    return en;
  endfunction

  // input carrying the n-th channel of the scan, in a..d order
  function automatic logic [1:0] input_of(input aps_word_t c, input logic [1:0] n);
    logic [3:0] en;
    logic [2:0] seen;
    logic [1:0] pick;
    en   = active_inputs(c);
    seen = 3'h0;
    pick = 2'h0;
    for (int i = 0; i < APS_NIN; i++)
    begin
      if (en[i] && seen == {1'b0, n}) pick = 2'(i);
      if (en[i]) seen = seen + 3'h1;
    end
    return pick;
  endfunction

  // channels in the scan; an empty selection behaves as one channel so
  // the scan never stalls
  function automatic logic [2:0] eff_count(input aps_word_t c);
    logic [3:0] en;
    logic [2:0] n;
    en = active_inputs(c);
    n  = 3'(en[0]) + 3'(en[1]) + 3'(en[2]) + 3'(en[3]);
    return (n == 3'h0) ? 3'h1 : n;
  endfunction

  wire [2:0] n_eff   = eff_count(cr0);
  wire       multi   = (n_eff > 3'h1);
  wire [1:0] last_ix = 2'(n_eff - 3'h1);

  // ----------------------------------------
  // access qualifiers
  // ----------------------------------------
  // both selects must agree before anything is seen (see R1, R2)
  wire sel     = port.select_active_high && !port.select_active_low_n;
  wire wr_only = cr1[APS_CR1_WRONLY];
  // line low is a write in either strobe mode (see R10)
  wire wr_act  = sel && !port.write_strobe_n;
  // separate read strobe only counts in strobe mode (see R11)
  wire rd_req  = wr_only ? !port.read_strobe_n : port.write_strobe_n;
  wire rd_act  = sel && rd_req;  // see R3
  wire commit  = wr_prev && !wr_act;

  // ----------------------------------------
  // bus drive
  // ----------------------------------------
  // released at once when the qualifier drops, avoiding contention (see R18)
  assign port.dev_data_oe  = rd_act;  // see R3
  assign port.dev_data_out = out_word;  // see R7

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  // bus and address are tracked through the strobe and stored as it
  // ends, so data settling late in the strobe is still caught
  always_ff @(posedge CLK)
  begin
    wr_prev <= !RST && wr_act;
    if (wr_act)
    begin
      wr_data <= port.data_bus_bits;  // see R7
      wr_addr <= {port.reg_addr_bit1, port.reg_addr_bit0};
    end
  end

  wire wr_cr0  = commit && wr_addr == APS_ADDR_CR0;  // see R8
  wire wr_cr1  = commit && wr_addr == APS_ADDR_CR1;  // see R8
  // a new channel set or an explicit request restarts the marker
  wire seq_rst = wr_cr0 || (wr_cr1 && wr_data[APS_CR1_SYNCRST]);

  // control registers; unknown addresses are dropped silently
  always_ff @(posedge CLK)
  begin
    if (RST) cr0 <= APS_CR0_RST;
    else if (wr_cr0) cr0 <= wr_data;
    if (RST) cr1 <= APS_CR1_RST;
    else if (wr_cr1) cr1 <= wr_data;
  end

  // ----------------------------------------
  // user-side status
  // ----------------------------------------
  // the reference choice follows register 0 directly (see R9)
  always_ff @(posedge CLK)
  begin
    REF_EXTERNAL <= !RST && cr0[APS_CR0_REFEXT];  // see R9
    CHAN_COUNT   <= RST ? 3'h1 : n_eff;
  end

  // ----------------------------------------
  // conversion clock edge
  // ----------------------------------------
  // the host's clock is only sampled; a falling edge is one enable pulse
  always_ff @(posedge CLK)
  begin
    cc_prev <= RST ? 1'b1 : port.conversion_clock;
  end
  wire conv_fall = cc_prev && !port.conversion_clock;  // see R14

  // ----------------------------------------
  // channel scan and sampling
  // ----------------------------------------
  // all four inputs are frozen together at channel one of each scan,
  // so the later words of that scan share the same instant (see R17)
  wire      first_now = (idx == 2'h0);
  wire [1:0] src      = input_of(cr0, idx);
  wire aps_word_t word = first_now ? SAMPLE[src] : held[src];

  always_ff @(posedge CLK)
  begin
    if (RST || seq_rst) idx <= 2'h0;
    else if (conv_fall) idx <= (idx >= last_ix) ? 2'h0 : idx + 2'h1;  // see R6
    if (RST) held <= '0;
    else if (conv_fall && first_now) held <= SAMPLE;  // see R17
  end

  // ----------------------------------------
  // conversion pipeline
  // ----------------------------------------
  // one stage per falling edge; the output register adds the last,
  // giving five edges from start to bus (see R15)
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      pipe_data[0]  <= '0;
      pipe_first[0] <= 1'b0;
    end
    else if (conv_fall)
    begin
      pipe_data[0]  <= word;  // see R14
      pipe_first[0] <= first_now;
    end
  end

  genvar g;
  generate
    for (g = 1; g < APS_LATENCY; g++)
    begin : g_stage
      always_ff @(posedge CLK)
      begin
        if (RST)
        begin
          pipe_data[g]  <= '0;
          pipe_first[g] <= 1'b0;
        end
        else if (conv_fall)
        begin
          pipe_data[g]  <= pipe_data[g-1];
          pipe_first[g] <= pipe_first[g-1];
        end
      end
    end
  endgenerate

  // output word changes only on a conversion edge, which can fall in the middle of a read
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      out_word  <= '0;
      out_first <= 1'b0;
    end
    else if (conv_fall)
    begin
      out_word  <= pipe_data[APS_LATENCY-1];  // see R15
      out_first <= pipe_first[APS_LATENCY-1];
    end
  end

  // ----------------------------------------
  // first-channel marker
  // ----------------------------------------
  // the count comes from the channel set being written, since cr0
  // only takes that set at the same edge
  wire aps_word_t hold_cfg  = RST ? APS_CR0_RST : (wr_cr0 ? wr_data : cr0);
  wire [3:0]      hold_load = 4'(APS_SYNC_BASE) + {1'b0, eff_count(hold_cfg)};

  // the hold counter covers the pipeline still carrying the old scan
  always_ff @(posedge CLK)
  begin
    if (RST || seq_rst) hold_cnt <= hold_load;  // see R16
    else if (conv_fall && hold_cnt != 4'h0) hold_cnt <= hold_cnt - 4'h1;
  end

  // held high in single-channel use, low with channel one (see R4, R5)
  assign port.first_channel_marker_n = !(multi && hold_cnt == 4'h0 && out_first);
endmodule

// [hdl/aps_host.sv]
// Purpose: processor-side end driving the converter port
// Assumes: one command at a time; conversion clock made here
// Notes:   reads before the first write are refused with an error
`timescale 1ns/1ps
module aps_host
  import aps_pkg::*;
(
  input  wire logic            CLK,        // system clock
  input  wire logic            RST,        // sync reset, high
  input  wire logic            CMD_VALID,  // command offered
  output logic                 CMD_READY,  // command taken
  input  wire logic            CMD_WRITE,  // 1 write, 0 read
  input  wire logic [1:0]      CMD_ADDR,   // register address
  input  wire aps_pkg::aps_word_t CMD_WDATA, // write data
  output logic                 RSP_VALID,  // read answer pulse
  output logic                 RSP_ERR,    // read refused
  output aps_pkg::aps_word_t   RSP_DATA,   // read data
  output logic                 MARK_SEEN,  // first-channel marker seen
  aps_if.host                  port        // device pins
);
  typedef enum logic [1:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD} aps_hst_t;
  aps_hst_t   state;
  aps_hst_t   next_state;
  logic [4:0] half_cnt;
  logic       conv;
  logic [1:0] stb_cnt;
  logic       is_wr;
  logic [1:0] addr;
  aps_word_t  wdata;
  logic       wr_only;
  logic       init_done;

  // ----------------------------------------
  // free-running 50% conversion clock
  // ----------------------------------------
  // even split of the period keeps the duty cycle exact (see R13)
  always_ff @(posedge CLK)
  begin
    if (RST || half_cnt == APS_HALF_W) half_cnt <= '0;
    else half_cnt <= half_cnt + 5'h01;
    if (RST) conv <= 1'b1;
    else if (half_cnt == APS_HALF_W) conv <= ~conv;
  end
  assign port.conversion_clock = conv;

  // ----------------------------------------
  // bus cycle sequencer
  // ----------------------------------------
  wire take      = (state == S_IDLE) && CMD_VALID;
  wire refuse    = take && !CMD_WRITE && !init_done;  // see R12
  wire strobe_on = (state == S_STROBE);
  assign CMD_READY = (state == S_IDLE);

  always_comb
  begin
    next_state = state;
    case (state)
      S_IDLE:   if (take && !refuse) next_state = S_SETUP;
      S_SETUP:  next_state = S_STROBE;
      S_STROBE: if (stb_cnt == APS_STB_W) next_state = S_HOLD;
      S_HOLD:   next_state = S_IDLE;
      default:  next_state = S_IDLE;
    endcase
  end

  // command capture, mode shadow and answer
  always_ff @(posedge CLK)
  begin
    state     <= RST ? S_IDLE : next_state;
    stb_cnt   <= strobe_on ? stb_cnt + 2'h1 : 2'h0;
    RSP_VALID <= !RST && (refuse || (strobe_on && stb_cnt == APS_STB_W && !is_wr));
    RSP_ERR   <= !RST && refuse;
    MARK_SEEN <= !RST && !port.first_channel_marker_n;
    if (take)
    begin
      is_wr <= CMD_WRITE;
      addr  <= CMD_ADDR;
      wdata <= CMD_WDATA;
    end
    if (RST) RSP_DATA <= '0;
    else if (strobe_on && stb_cnt == APS_STB_W) RSP_DATA <= port.data_bus_bits;
    if (RST)
    begin
      wr_only   <= 1'b0;
      init_done <= 1'b0;
    end
    else if (state == S_HOLD && is_wr)
    begin
      init_done <= 1'b1;
      if (addr == APS_ADDR_CR1) wr_only <= wdata[APS_CR1_WRONLY];  // see R10
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  // select both ways for the whole strobe (see R1, R2)
  assign port.select_active_high  = strobe_on;
  assign port.select_active_low_n = !strobe_on;
  assign port.reg_addr_bit0       = addr[0];  // see R8
  assign port.reg_addr_bit1       = addr[1];
  // combined mode: line low means write; else separate strobes (see R10, R11)
  assign port.write_strobe_n = !(strobe_on && is_wr);
  assign port.read_strobe_n  = !(strobe_on && !is_wr && wr_only);
  // data held through setup and hold, off on reads (see R7)
  assign port.host_data_oe  = is_wr && state != S_IDLE;
  assign port.host_data_out = wdata;
endmodule

// [hdl/aps_if.sv]
// Purpose: pins between converter sequencer and its host
// Assumes: all pins synchronous to CLK
// Notes:   data bus level resolved here from both enables
`timescale 1ns/1ps
interface aps_if;
  import aps_pkg::*;
  logic      select_active_high;
  logic      select_active_low_n;
  logic      read_strobe_n;
  logic      write_strobe_n;
  logic      reg_addr_bit0;
  logic      reg_addr_bit1;
  logic      conversion_clock;
  logic      first_channel_marker_n;
  aps_word_t host_data_out;
  logic      host_data_oe;
  aps_word_t dev_data_out;
  logic      dev_data_oe;
  aps_word_t data_bus_bits;

  // undriven bus reads as zero, host wins only when device is off
  assign data_bus_bits = dev_data_oe  ? dev_data_out :
                         host_data_oe ? host_data_out : '0;

  modport dev (input select_active_high, select_active_low_n, read_strobe_n,
               write_strobe_n, reg_addr_bit0, reg_addr_bit1, conversion_clock,
               data_bus_bits, output first_channel_marker_n, dev_data_out,
               dev_data_oe);
  modport host (output select_active_high, select_active_low_n, read_strobe_n,
                write_strobe_n, reg_addr_bit0, reg_addr_bit1, conversion_clock,
                host_data_out, host_data_oe, input data_bus_bits,
                first_channel_marker_n);
endinterface

// [hdl/aps_pkg.sv]
// Purpose: shared constants of the parallel-port converter sequencer
// Assumes: 100 MHz system clock on both ends
// Notes:   control register layouts are local choices
package aps_pkg;
  // ----------------------------------------
  // widths and sequencing
  // ----------------------------------------
  localparam int APS_DW        = 10;  // data bus width
  localparam int APS_NIN       = 4;   // analog inputs
  localparam int APS_LATENCY   = 5;   // conversion clock cycles
  localparam int APS_SYNC_BASE = 7;   // marker hold base count
  typedef logic [APS_DW-1:0] aps_word_t;
  typedef logic [APS_NIN-1:0][APS_DW-1:0] aps_set_t;

  // ----------------------------------------
  // register addresses and fields
  // ----------------------------------------
  localparam logic [1:0] APS_ADDR_CR0   = 2'h0;
  localparam logic [1:0] APS_ADDR_CR1   = 2'h1;
  localparam int APS_CR0_REFEXT  = 0;  // 1 = external reference
  localparam int APS_CR0_CHEN    = 1;  // 4-bit input enable, a..d
  localparam int APS_CR0_DIFF_AB = 5;  // a/b form one differential pair
  localparam int APS_CR0_DIFF_CD = 6;  // c/d form one differential pair
  localparam int APS_CR1_WRONLY  = 0;  // 1 = separate write strobe
  localparam int APS_CR1_SYNCRST = 1;  // write 1 restarts marker sequence
  localparam aps_word_t APS_CR0_RST = 10'h002;  // input a, internal ref
  localparam aps_word_t APS_CR1_RST = 10'h000;  // combined r/w line

  // ----------------------------------------
  // host timing
  // ----------------------------------------
  localparam int APS_CLK_MHZ      = 100;
  localparam int APS_CONV_NS      = 180;  // conversion clock period
  localparam int APS_CONV_HALF    = (APS_CONV_NS * APS_CLK_MHZ) / 2000;
  localparam int APS_STROBE_CYC   = 3;    // strobe length in clocks
  localparam logic [4:0] APS_HALF_W = 5'(APS_CONV_HALF - 1);
  localparam logic [1:0] APS_STB_W  = 2'(APS_STROBE_CYC - 1);
endpackage

// [test/adc_parallel_port_sequencer_test.sv]
// Purpose: host commands and samples in, both port ends checked
// Assumes: host makes the conversion clock
// Notes:   expected words come from bench history, never outputs
`timescale 1ns/1ps
module adc_parallel_port_sequencer_test;
  import aps_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       cmd_valid = 1'b0;
  logic       cmd_ready;
  logic       cmd_write = 1'b0;
  logic [1:0] cmd_addr = 2'h0;
  aps_word_t  cmd_wdata = 10'h000;
  logic       rsp_valid;
  logic       rsp_err;
  aps_word_t  rsp_data;
  logic       mark_seen;
  logic       ref_external;
  logic [2:0] chan_count;
  aps_set_t   sample = '0;
  logic       cc_q = 1'b1;
  integer     seed = 9;
  int         num_errors = 0;
  int         total_checks = 0;
  aps_word_t  hist [32];
  aps_word_t  cfgs [4] = '{10'h01e, 10'h07f, 10'h026, 10'h00c};

  aps_if port_if ();
  aps_host aps_host_i (.CLK(clk), .RST(rst), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_WRITE(cmd_write),
    .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata), .RSP_VALID(rsp_valid), .RSP_ERR(rsp_err), .RSP_DATA(rsp_data),
    .MARK_SEEN(mark_seen), .port(port_if));
  aps_dev aps_dev_i (.CLK(clk), .RST(rst), .SAMPLE(sample), .REF_EXTERNAL(ref_external), .CHAN_COUNT(chan_count),
    .port(port_if));
  aps_properties aps_properties_i (.CLK(clk), .RST(rst), .select_active_high(port_if.select_active_high),
    .select_active_low_n(port_if.select_active_low_n), .read_strobe_n(port_if.read_strobe_n),
    .write_strobe_n(port_if.write_strobe_n), .conversion_clock(port_if.conversion_clock),
    .first_channel_marker_n(port_if.first_channel_marker_n), .host_data_oe(port_if.host_data_oe),
    .dev_data_out(port_if.dev_data_out), .dev_data_oe(port_if.dev_data_oe));

  // clock and a copy of the conversion clock for fall detection
  always #5 clk = ~clk;
  always @(posedge clk) cc_q <= port_if.conversion_clock;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input bit ok, input string msg);
    total_checks++;
    if (!ok)
    begin
      num_errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // phase 0 waits for take, phase 1 for idle (write) or answer (read)
  task automatic cmd(input logic wr, input logic [1:0] a, input aps_word_t d, output aps_word_t rd, output logic er);
    int n;
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_addr  <= a;
    cmd_wdata <= d;
    for (int ph = 0; ph < 2; ph++)
    begin
      n = 0;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (((ph == 0 || wr) ? cmd_ready : rsp_valid) !== 1'b1 && n < 50);
      cmd_valid <= 1'b0;
      chk(n < 50, "command stalled");
    end
    rd = rsp_data;
    er = rsp_err;
  endtask

  // word and marker sampled at a fall edge belong to the previous word
  task automatic next_fall(output aps_word_t w, output logic mk);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (!(cc_q === 1'b1 && port_if.conversion_clock === 1'b0) && n < 60);
    chk(n < 60, "conversion clock stalled");
    w  = port_if.dev_data_out;
    mk = port_if.first_channel_marker_n;
    chk(mark_seen === ~mk, "marker copy differs");
  endtask

  function automatic int chans(input aps_word_t c, output int lst[4]);
    int n;
    n = 0;
    for (int i = 0; i < 4; i++)
      if (c[APS_CR0_CHEN + i] && !(i == 1 && c[APS_CR0_DIFF_AB]) && !(i == 3 && c[APS_CR0_DIFF_CD]))
      begin
        lst[n] = i;
        n++;
      end
    return n;
  endfunction

  task automatic reset_check();
    aps_word_t rd;
    logic      er;
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(ref_external === APS_CR0_RST[0] && chan_count === 3'h1, "reset values");
    cmd(1'b0, APS_ADDR_CR0, 10'h000, rd, er);
    chk(er === 1'b1, "read before write not refused");
  endtask

  // constant inputs, so the scan order and marker place are visible
  task automatic scan_check(input aps_word_t cfg);
    int        lst[4];
    int        n;
    int        first;
    aps_word_t w;
    aps_word_t rd;
    logic      mk;
    logic      er;
    n = chans(cfg, lst);
    for (int j = 0; j < 4; j++)
      sample[j] <= 10'($random(seed));
    cmd(1'b1, APS_ADDR_CR0, cfg, rd, er);
    // scans selecting the external reference restart the marker again through the explicit request
    if (cfg[APS_CR0_REFEXT])
      cmd(1'b1, APS_ADDR_CR1, 10'h003, rd, er);
    @(posedge clk);
    chk(ref_external === cfg[APS_CR0_REFEXT], "reference select");
    chk(chan_count === 3'(n), "channel count");
    first = 0;
    for (int f = 1; f < 10 + 4 * n; f++)
    begin
      next_fall(w, mk);
      if (n == 1)
        chk(mk === 1'b1, "marker active in single channel");
      else
      begin
        if (first == 0 && mk === 1'b0)
        begin
          first = f;
          chk(f >= APS_SYNC_BASE + n && f <= 8 + 2 * n, "first marker delay");
        end
        if (first != 0)
        begin
          chk(mk === ((f - first) % n != 0), "marker position");
          chk(w === sample[lst[(f - first) % n]], "channel order");
        end
      end
    end
    if (n > 1)
      chk(first != 0, "marker never seen");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    logic [3:0] en;
    logic [1:0] df;
    aps_word_t  w;
    aps_word_t  rd;
    logic       mk;
    logic       er;
    reset_check();
    cmd(1'b1, APS_ADDR_CR0, 10'h002, rd, er);
    for (int k = 0; k < 20; k++)
    begin
      next_fall(w, mk);
      hist[k] = sample[0];
      sample[0] <= 10'($random(seed));
      if (k >= 6)
        chk(w === hist[k - 6], "pipeline latency");
      chk(mk === 1'b1, "marker idle");
    end
    sample[0] <= 10'h2a5;
    repeat (8) next_fall(w, mk);
    cmd(1'b0, APS_ADDR_CR0, 10'h000, rd, er);
    chk(rd === 10'h2a5 && er === 1'b0, "combined mode read");
    cmd(1'b1, APS_ADDR_CR1, 10'h001, rd, er);
    cmd(1'b0, APS_ADDR_CR0, 10'h000, rd, er);
    chk(rd === 10'h2a5 && er === 1'b0, "strobe mode read");
    for (int a = 2; a < 4; a++)
    begin
      cmd(1'b1, 2'(a), 10'h3ff, rd, er);
      @(posedge clk);
      chk(ref_external === 1'b0 && chan_count === 3'h1, "unmapped write took effect");
    end
    for (int i = 0; i < 7; i++)
    begin
      en = 4'($random(seed));
      df = 2'($random(seed));
      en[1:0] = df[0] ? 2'h3 : en[1:0];
      en[3:2] = df[1] ? 2'h3 : en[3:2];
      en[0] = en[0] | (en == 4'h0);
      scan_check(i < 4 ? cfgs[i] : {3'h0, df, en, 1'($random(seed))});
    end
    reset_check();
    tally_and_finish();
  end

  // watchdog well beyond the expected few thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    chk(1'b0, "watchdog expired");
    tally_and_finish();
  end
endmodule

// [test/aps_properties.sv]
// Purpose: timing checks on the pins between host end and device end
// Assumes: one clock domain, sync reset high
// Notes:   falls are seen the way the device sees them, one CLK late
`timescale 1ns/1ps
module aps_properties
  import aps_pkg::*;
(
  input wire logic               CLK,                    // clock
  input wire logic               RST,                    // reset
  input wire logic               select_active_high,     // high select
  input wire logic               select_active_low_n,    // low select
  input wire logic               read_strobe_n,          // read strobe
  input wire logic               write_strobe_n,         // write line
  input wire logic               conversion_clock,       // conv clock
  input wire logic               first_channel_marker_n, // marker
  input wire logic               host_data_oe,           // host drives
  input wire aps_pkg::aps_word_t dev_data_out,           // device word
  input wire logic               dev_data_oe             // device drives
);
  logic       cc_q;
  logic       tog_seen;
  logic       written;
  logic [7:0] run_len;
  wire        sel    = select_active_high & ~select_active_low_n;
  wire        cc_tog = conversion_clock != cc_q;

  // run length of clock levels; the first run after reset is partial, so skipped
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      cc_q     <= 1'b1;
      tog_seen <= 1'b0;
      written  <= 1'b0;
      run_len  <= 8'h00;
    end
    else
    begin
      cc_q     <= conversion_clock;
      tog_seen <= tog_seen | cc_tog;
      written  <= written | (sel & ~write_strobe_n);
      run_len  <= cc_tog ? 8'h01 : run_len + 8'h01;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  sel_high_a: assert property (dev_data_oe |-> select_active_high)
    else $error("bus driven without high select");
  sel_low_a: assert property (dev_data_oe |-> !select_active_low_n)
    else $error("bus driven without low select");
  rd_dir_a: assert property (dev_data_oe |-> write_strobe_n)
    else $error("bus driven during write");
  rd_qual_a: assert property (sel && write_strobe_n && !read_strobe_n |-> dev_data_oe)
    else $error("read qualifier did not drive bus");
  wr_drive_a: assert property (sel && !write_strobe_n |-> host_data_oe && !dev_data_oe)
    else $error("write without host data");
  data_hold_a: assert property ($changed(dev_data_out) |-> $past(conversion_clock, 2) && !$past(conversion_clock))
    else $error("word changed away from a clock fall");
  mark_word_a: assert property (!first_channel_marker_n && $past(conversion_clock) && !conversion_clock
                                |=> first_channel_marker_n)
    else $error("marker held past one word");
  first_write_a: assert property (sel && write_strobe_n |-> written)
    else $error("read before first write");
  clk_duty_a: assert property (cc_tog && tog_seen |-> run_len == 8'(APS_CONV_HALF))
    else $error("conversion clock half period wrong");
  bus_clash_a: assert property (!(dev_data_oe && host_data_oe))
    else $error("both ends drive the data bus");
endmodule
